// ===== hdl/tw_master.sv
// Two-wire master with flag handshake: core-side control and link-side bus engine
//
// What this block does
// - Sets the completion flag after each handled bus event except a STOP.
// - Interrupt request only when flag, local enable and global enable are set.
// - Status holds an event code while the flag is set, one cycle late.
// - Writing one to the flag bit clears it; zero leaves it.
// - No new bus operation starts while the flag is set.
// - Clearing the flag with start requested begins a START at once.
// - After START is sent, flag set with START code, or repeated START code if the bus was already held.
// - Address byte sent, then flag set with acknowledge or not code.
// - Data byte sent, then flag set with acknowledge or not code.
// - Finishing a STOP does not set the flag.
// - SCL held low while the flag is set.
// - Control written last with flag bit; device runs the requested operation.
// - One shift data register carries address and data bytes.
// - Status takes the event code the cycle after the flag rises.
// - Status shows the no-information code while the flag is clear, one cycle late.
`default_nettype none
module tw_master #(
	parameter logic [15:0] QUARTER = tw_pkg::QUARTER_TICKS
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control writes
	input wire logic ctrl_wr,
	input wire tw_pkg::tw_ctrl_type ctrl_wdata,
	// Shift data writes
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	// Processor global interrupt enable
	input wire logic cpu_global_ie,
	// Status towards software
	output logic op_done,
	output logic [7:0] bus_status_reg,
	output logic [7:0] shift_data_reg,
	output logic write_collision,
	output logic busy,
	output logic irq,
	// Link clock and bus pins
	input wire logic link_clk,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);

	// Core-side state
	logic op_enable;
	logic op_irq_enable;
	logic [1:0] prescale;
	tw_pkg::tw_cmd_type pend_cmd;
	logic cmd_pending;
	tw_pkg::tw_cmd_type link_cmd;
	logic req_tog;
	logic done_sync;
	logic done_seen;
	logic done_pulse;
	logic first_byte;
	logic [7:0] ev_code;
	logic [7:0] next_code;

	// Link-side state
	logic link_reset;
	logic req_sync;
	logic req_seen;
	logic req_pulse;
	logic [2:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic en_s;
	tw_pkg::tw_link_state_type lstate;
	logic [1:0] ph;
	logic [3:0] bitn;
	logic [15:0] cnt;
	logic [1:0] lps;
	logic [7:0] sh;
	logic owned;
	logic scl_low;
	logic sda_low;
	logic done_tog;
	tw_pkg::tw_result_type result;
	logic tick;
	logic advance;

	// Core domain

	// Control settings stored from every control write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_enable <= 1'b0;
			op_irq_enable <= 1'b0;
			prescale <= tw_pkg::PRESCALE_RESET;
		end else if (ctrl_wr) begin
			op_enable <= ctrl_wdata.enable;
			op_irq_enable <= ctrl_wdata.irq_enable;
			prescale <= ctrl_wdata.prescale;
		end
	end

	// Data writes only land while the flag is set
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shift_data_reg <= tw_pkg::SHIFT_DATA_RESET;
			write_collision <= 1'b0;
		end else if (data_wr) begin
			if (op_done) begin
				shift_data_reg <= data_wdata;
				write_collision <= 1'b0;
			end else begin
				write_collision <= 1'b1;
			end
		end
	end

	// A control write with the flag bit chooses the next operation
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pend_cmd <= '0;
			cmd_pending <= 1'b0;
		end else if (ctrl_wr && ctrl_wdata.flag_clear && ctrl_wdata.enable) begin
			if (ctrl_wdata.start_req) begin
				pend_cmd.op <= tw_pkg::OP_START;
			end else if (ctrl_wdata.stop_req) begin
				pend_cmd.op <= tw_pkg::OP_STOP;
			end else begin
				pend_cmd.op <= tw_pkg::OP_BYTE;
			end
			pend_cmd.data <= (data_wr && op_done) ? data_wdata : shift_data_reg;
			pend_cmd.prescale <= ctrl_wdata.prescale;
			cmd_pending <= 1'b1;
		end else if (cmd_pending && !busy && !op_done) begin
			cmd_pending <= 1'b0;
		end
	end

	// Hand one command at a time to the link; the word stays still until done
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_cmd <= '0;
			req_tog <= 1'b0;
			busy <= 1'b0;
		end else if (cmd_pending && !busy && !op_done) begin
			link_cmd <= pend_cmd;
			req_tog <= ~req_tog;
			busy <= 1'b1;
		end else if (done_pulse) begin
			busy <= 1'b0;
		end
	end

	tw_sync #(.WIDTH(1)) u_done_sync (
		.clk(core_clk),
		.async_in(done_tog),
		.sync_out(done_sync)
	);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			done_seen <= 1'b0;
		end else begin
			done_seen <= done_sync;
		end
	end

	assign done_pulse = done_sync ^ done_seen;

	// Event code from the result word, which is stable once the toggle arrives
	always_comb begin
		case (result.kind)
			tw_pkg::EV_START: next_code = tw_pkg::CODE_START;
			tw_pkg::EV_REP_START: next_code = tw_pkg::CODE_REP_START;
			default: begin
				if (first_byte) begin
					next_code = result.nack ? tw_pkg::CODE_ADDR_NACK : tw_pkg::CODE_ADDR_ACK;
				end else begin
					next_code = result.nack ? tw_pkg::CODE_DATA_NACK : tw_pkg::CODE_DATA_ACK;
				end
			end
		endcase
	end

	// Flag: set on a reported event, cleared by a one in the flag bit; set wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_done <= 1'b0;
			ev_code <= tw_pkg::CODE_NO_INFO;
			first_byte <= 1'b0;
		end else begin
			if (ctrl_wr && ctrl_wdata.flag_clear) begin
				op_done <= 1'b0;
			end
			if (done_pulse && result.kind != tw_pkg::EV_NONE) begin
				op_done <= 1'b1;
				ev_code <= next_code;
				first_byte <= (result.kind != tw_pkg::EV_BYTE);
			end
		end
	end

	// Status follows the flag by one cycle and hides stale codes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_status_reg <= tw_pkg::CODE_NO_INFO;
		end else if (op_done) begin
			bus_status_reg <= (ev_code & tw_pkg::CODE_MASK) | {6'h00, prescale};
		end else begin
			bus_status_reg <= tw_pkg::CODE_NO_INFO;
		end
	end

	assign irq = op_done && op_irq_enable && cpu_global_ie;

	// Link domain

	tw_sync #(.WIDTH(1)) u_reset_sync (
		.clk(link_clk),
		.async_in(reset),
		.sync_out(link_reset)
	);

	tw_sync #(.WIDTH(1)) u_req_sync (
		.clk(link_clk),
		.async_in(req_tog),
		.sync_out(req_sync)
	);

	tw_sync #(.WIDTH(3)) u_pin_sync (
		.clk(link_clk),
		.async_in({op_enable, sda_in, scl_in}),
		.sync_out(pins_sync)
	);

	assign scl_s = pins_sync[0];
	assign sda_s = pins_sync[1];
	assign en_s = pins_sync[2];

	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			req_seen <= 1'b0;
		end else begin
			req_seen <= req_sync;
		end
	end

	assign req_pulse = req_sync ^ req_seen;

	// Quarter-period ticks; a slave holding SCL low stalls the high phase
	assign tick = (cnt == 16'h0000);
	assign advance = tick && !(ph == 2'd2 && !scl_s);

	always_ff @(posedge link_clk) begin
		if (link_reset || req_pulse || tick) begin
			cnt <= 16'(QUARTER << {lps, 1'b0});
		end else begin
			cnt <= cnt - 16'h0001;
		end
	end

	// Bus engine: each bit takes four quarter phases
	always_ff @(posedge link_clk) begin
		if (link_reset || !en_s) begin
			lstate <= tw_pkg::LS_IDLE;
			ph <= 2'd0;
			bitn <= 4'h0;
			lps <= tw_pkg::PRESCALE_RESET;
			sh <= tw_pkg::SHIFT_DATA_RESET;
			owned <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			result <= '0;
		end else if (req_pulse) begin
			// A stale byte result must not raise the flag when an idle STOP completes at once
			result.kind <= tw_pkg::EV_NONE;
			ph <= 2'd0;
			bitn <= 4'h0;
			lps <= link_cmd.prescale;
			sh <= link_cmd.data;
			case (link_cmd.op)
				tw_pkg::OP_START: lstate <= tw_pkg::LS_START;
				tw_pkg::OP_STOP: lstate <= owned ? tw_pkg::LS_STOP : tw_pkg::LS_IDLE;
				default: lstate <= tw_pkg::LS_BYTE;
			endcase
		end else if (advance) begin
			ph <= ph + 2'd1;
			case (lstate)
				tw_pkg::LS_START: begin
					case (ph)
						2'd0: sda_low <= 1'b0;
						2'd1: scl_low <= 1'b0;
						2'd2: sda_low <= 1'b1;
						default: begin
							scl_low <= 1'b1;
							owned <= 1'b1;
							result.kind <= owned ? tw_pkg::EV_REP_START : tw_pkg::EV_START;
							lstate <= tw_pkg::LS_HOLD;
						end
					endcase
				end
				tw_pkg::LS_BYTE: begin
					case (ph)
						2'd0: sda_low <= (bitn == tw_pkg::ACK_BIT_INDEX) ? 1'b0 : !sh[7];
						2'd1: scl_low <= 1'b0;
						2'd2: begin
							if (bitn == tw_pkg::ACK_BIT_INDEX) begin
								result.nack <= sda_s;
							end
						end
						default: begin
							scl_low <= 1'b1;
							sh <= {sh[6:0], 1'b0};
							if (bitn == tw_pkg::ACK_BIT_INDEX) begin
								result.kind <= tw_pkg::EV_BYTE;
								lstate <= tw_pkg::LS_HOLD;
							end else begin
								bitn <= bitn + 4'h1;
							end
						end
					endcase
				end
				tw_pkg::LS_STOP: begin
					case (ph)
						2'd0: sda_low <= 1'b1;
						2'd1: scl_low <= 1'b0;
						2'd2: sda_low <= 1'b0;
						default: begin
							owned <= 1'b0;
							result.kind <= tw_pkg::EV_NONE;
							lstate <= tw_pkg::LS_IDLE;
						end
					endcase
				end
				default: ph <= 2'd0;
			endcase
		end
	end

	// Completion toggle, raised as the engine settles after an operation
	always_ff @(posedge link_clk) begin
		if (link_reset) begin
			done_tog <= 1'b0;
		end else if (advance && ph == 2'd3 &&
				(lstate == tw_pkg::LS_START || lstate == tw_pkg::LS_STOP ||
				(lstate == tw_pkg::LS_BYTE && bitn == tw_pkg::ACK_BIT_INDEX))) begin
			done_tog <= ~done_tog;
		end else if (req_pulse && link_cmd.op == tw_pkg::OP_STOP && !owned) begin
			done_tog <= ~done_tog;
		end
	end

	// Open-drain pins: the enable goes low to pull a line down
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = !scl_low;
	assign sda_oe_n = !sda_low;

endmodule : tw_master
`default_nettype wire

// ===== hdl/tw_pkg.sv
// Shared constants and types of the two-wire master handshake block
`default_nettype none
package tw_pkg;

	// Status codes; while the flag is set the low three bits carry the prescaler and a reserved zero
	localparam logic [7:0] CODE_START = 8'h08;
	localparam logic [7:0] CODE_REP_START = 8'h10;
	localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
	localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
	localparam logic [7:0] CODE_DATA_ACK = 8'h28;
	localparam logic [7:0] CODE_DATA_NACK = 8'h30;
	localparam logic [7:0] CODE_NO_INFO = 8'hf8;
	localparam logic [7:0] CODE_MASK = 8'hf8;

	// Status field positions
	localparam int STATUS_PS_LSB = 0;
	localparam int STATUS_CODE_LSB = 3;

	// Reset values
	localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;

	// Bus timing: link clock ticks per quarter of an SCL period, before prescaling
	localparam logic [15:0] QUARTER_TICKS = 16'h000a;
	localparam logic [3:0] ACK_BIT_INDEX = 4'h8;

	// Operation carried out after the flag is cleared
	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_BYTE = 2'b01,
		OP_STOP = 2'b10
	} tw_op_type;

	// Bus event reported back by the link side
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_START = 2'b01,
		EV_REP_START = 2'b10,
		EV_BYTE = 2'b11
	} tw_event_type;

	// Link engine states
	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_START = 3'b001,
		LS_BYTE = 3'b010,
		LS_STOP = 3'b011,
		LS_HOLD = 3'b100
	} tw_link_state_type;

	// Software write to the control settings
	typedef struct packed {
		logic flag_clear;
		logic start_req;
		logic stop_req;
		logic enable;
		logic irq_enable;
		logic [1:0] prescale;
	} tw_ctrl_type;

	// Command handed to the link side
	typedef struct packed {
		tw_op_type op;
		logic [7:0] data;
		logic [1:0] prescale;
	} tw_cmd_type;

	// Result handed back to the core side
	typedef struct packed {
		tw_event_type kind;
		logic nack;
	} tw_result_type;

endpackage : tw_pkg
`default_nettype wire

// ===== hdl/tw_sync.sv
// Two-flop synchroniser for signals entering a clock domain
`default_nettype none
module tw_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock
	input wire logic clk,
	// Asynchronous source and synchronised copy
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// The first stage feeds the second and nothing else
	always_ff @(posedge clk) begin
		meta <= async_in;
		sync_out <= meta;
	end

endmodule : tw_sync
`default_nettype wire

// ===== testbench/tw_master_props.sv
// Checker of the two-wire master's core-side port behaviour
`default_nettype none
module tw_master_props (
	// Core side
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ctrl_wr,
	input wire tw_pkg::tw_ctrl_type ctrl_wdata,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic cpu_global_ie,
	input wire logic op_done,
	input wire logic [7:0] bus_status_reg,
	input wire logic [7:0] shift_data_reg,
	input wire logic busy,
	input wire logic irq,
	// Bus pin
	input wire logic scl_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic clr;
	assign clr = ctrl_wr && ctrl_wdata.flag_clear;
	AST_IRQ: assert property (irq |-> op_done && cpu_global_ie)
		else $error("irq without flag or global enable");
	AST_NO_INFO: assert property (!op_done && !$past(op_done) |->
		bus_status_reg == tw_pkg::CODE_NO_INFO) else $error("status not idle code");
	AST_CODE: assert property (op_done && $past(op_done) |->
		(bus_status_reg & tw_pkg::CODE_MASK) != tw_pkg::CODE_NO_INFO)
		else $error("no event code while flag set");
	AST_CLEAR: assert property (clr && op_done |=> !op_done) else $error("flag not cleared");
	AST_KEEP: assert property (op_done && !clr |=> op_done) else $error("flag dropped");
	AST_WAIT: assert property ($rose(busy) |-> !$past(op_done))
		else $error("operation began while flag set");
	AST_HOLD: assert property (op_done |-> !scl_oe_n) else $error("clock released while flag set");
	AST_START: assert property (clr && ctrl_wdata.start_req &&
		ctrl_wdata.enable && !busy |-> ##[1:3] busy) else $error("start not launched");
	AST_LOAD: assert property (data_wr && op_done |=> shift_data_reg == $past(data_wdata))
		else $error("byte not loaded");
endmodule : tw_master_props
bind tw_master tw_master_props chk (.core_clk(core_clk), .reset(reset), .ctrl_wr(ctrl_wr),
	.ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
	.cpu_global_ie(cpu_global_ie), .op_done(op_done), .bus_status_reg(bus_status_reg),
	.shift_data_reg(shift_data_reg), .busy(busy), .irq(irq), .scl_oe_n(scl_oe_n));
`default_nettype wire

// ===== testbench/tw_master_tb.sv
// Self-checking bench of the two-wire master against a behavioural slave
`default_nettype none
module tw_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic reset = 1'b1;
	logic ctrl_wr = 1'b0;
	tw_pkg::tw_ctrl_type ctrl_wdata = '0;
	logic data_wr = 1'b0;
	logic [7:0] data_wdata = 8'h00;
	logic cpu_global_ie = 1'b0;
	logic op_done, write_collision, busy, irq, scl_out, sda_out, scl_oe_n, sda_oe_n;
	logic [7:0] bus_status_reg, shift_data_reg, rx_byte, addr;
	logic scl, sda, scl_pull, sda_pull, ps;
	logic nack = 1'b0;
	logic slow = 1'b0;
	logic seen_done = 1'b0;
	logic took = 1'b0;
	logic [7:0] expq[$];
	logic [31:0] r;
	integer seed = 32'h291e;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	// Both lines have pull-ups
	assign scl = scl_oe_n && !scl_pull;
	assign sda = sda_oe_n && !sda_pull;
	initial forever #20 core_clk = ~core_clk;
	initial begin
		#7;
		forever #7.5 link_clk = ~link_clk;
	end
	tw_master #(.QUARTER(16'h0002)) uut (.core_clk(core_clk), .reset(reset),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .data_wr(data_wr),
		.data_wdata(data_wdata), .cpu_global_ie(cpu_global_ie), .op_done(op_done),
		.bus_status_reg(bus_status_reg), .shift_data_reg(shift_data_reg),
		.write_collision(write_collision), .busy(busy), .irq(irq), .link_clk(link_clk),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));
	tw_slave_model slave (.scl(scl), .sda(sda), .nack(nack), .slow(slow),
		.scl_pull(scl_pull), .sda_pull(sda_pull), .rx_byte(rx_byte));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	// Optional byte load, then the control write that clears the flag
	task step(input logic st, input logic sp, input logic ld, input logic [7:0] b,
		input logic [7:0] code);
		@(negedge core_clk);
		if (ld) begin
			data_wr = 1'b1;
			data_wdata = b;
			@(negedge core_clk);
			data_wr = 1'b0;
		end
		ctrl_wr = 1'b1;
		ctrl_wdata = {1'b1, st, sp, 1'b1, 1'b1, 1'b0, ps};
		if (!sp) expq.push_back(code);
		@(negedge core_clk);
		ctrl_wr = 1'b0;
		repeat (sp ? 200 : 4000) begin
			@(negedge core_clk);
			if (!sp && op_done === 1'b1) break;
		end
		check({7'h00, op_done}, {7'h00, !sp});
		if (ld) check(rx_byte, b);
		repeat (3) @(negedge core_clk);
	endtask : step
	// The status is taken once per flag, a cycle after it rises, away from the launching edge
	always @(negedge core_clk) begin
		if (op_done !== 1'b1) took <= 1'b0;
		else if (seen_done && !took && expq.size() > 0) begin
			check(bus_status_reg & tw_pkg::CODE_MASK, expq.pop_front());
			took <= 1'b1;
		end
		seen_done <= (op_done === 1'b1);
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			end_of_test;
		end
	end
	initial begin
		r = $random(seed);
		ps = r[8];
		addr = {r[7:1], 1'b0};
		repeat (20) @(negedge core_clk);
		reset = 1'b0;
		check(bus_status_reg, tw_pkg::CODE_NO_INFO);
		data_wr = 1'b1;
		data_wdata = 8'h5a;
		@(negedge core_clk);
		data_wr = 1'b0;
		@(negedge core_clk);
		check({7'h00, write_collision}, 8'h01);
		check(shift_data_reg, 8'h00);
		$display("test idle state done");
		step(1'b1, 1'b0, 1'b0, 8'h00, tw_pkg::CODE_START);
		for (int i = 0; i < 4; i++) begin
			@(negedge core_clk);
			ctrl_wr = 1'b1;
			ctrl_wdata = {1'b0, 1'b0, 1'b0, 1'b1, i[0], 1'b0, ps};
			cpu_global_ie = i[1];
			@(negedge core_clk);
			ctrl_wr = 1'b0;
			check({7'h00, irq}, {7'h00, i == 3});
		end
		$display("test interrupt gating done");
		step(1'b0, 1'b0, 1'b1, addr, tw_pkg::CODE_ADDR_ACK);
		slow = 1'b1;
		r = $random(seed);
		step(1'b0, 1'b0, 1'b1, r[7:0], tw_pkg::CODE_DATA_ACK);
		slow = 1'b0;
		nack = 1'b1;
		step(1'b0, 1'b0, 1'b1, r[15:8], tw_pkg::CODE_DATA_NACK);
		nack = 1'b0;
		step(1'b1, 1'b0, 1'b0, 8'h00, tw_pkg::CODE_REP_START);
		nack = 1'b1;
		step(1'b0, 1'b0, 1'b1, addr ^ 8'h80, tw_pkg::CODE_ADDR_NACK);
		nack = 1'b0;
		step(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		check({4'h0, scl_out, sda_out, busy, scl & sda}, 8'h01);
		check(8'(expq.size()), 8'h00);
		$display("test transfer done");
		end_of_test;
	end
endmodule : tw_master_tb
`default_nettype wire

// ===== testbench/tw_slave_model.sv
// Behavioural two-wire slave that acknowledges bytes and may stretch the clock
`default_nettype none
module tw_slave_model (
	// Wire levels
	input wire logic scl,
	input wire logic sda,
	// Scenario controls
	input wire logic nack,
	input wire logic slow,
	// Pulls onto the wire and last byte taken
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int bits = 0;
	logic [7:0] shifter = 8'h00;
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		rx_byte = 8'h00;
	end
	// A start condition restarts the bit count
	always @(negedge sda) begin
		if (scl) bits = 0;
	end
	// Most significant bit first
	always @(posedge scl) begin
		if (bits < 8) shifter = {shifter[6:0], sda};
		bits = bits + 1;
		if (bits == 8) rx_byte = shifter;
	end
	// Stretch only after the acknowledge slot, never inside a bit
	always @(negedge scl) begin
		sda_pull = (bits == 8) && !nack;
		if (bits == 9) begin
			bits = 0;
			if (slow) begin
				scl_pull = 1'b1;
				#900 scl_pull = 1'b0;
			end
		end
	end
endmodule : tw_slave_model
`default_nettype wire
